// [inc/misc_csr_defines.svh]
`ifndef MISC_CSR_DEFINES_SVH
`define MISC_CSR_DEFINES_SVH

// register byte offsets
`define OFS_TIMER_NOW     8'h90
`define OFS_HALF_ORDER    8'h98
`define OFS_TICK_COUNT    8'h9c
`define OFS_LOST_FRAMES   8'ha0
`define OFS_MAC_COMMAND   8'ha4
`define OFS_MAC_VALUE     8'ha8

// field positions
`define CMD_BUSY_BIT      31
`define CMD_RNW_BIT       30
`define CMD_ADDR_MSB      7

// reset and pattern values
`define TIMER_RST         16'hffff
`define SWAP_RST          32'h00000000
`define SWAP_REVERSE      32'hffffffff
`define LOST_HALF_PREV    32'h7fffffff
`define LOST_HALF_AT      32'h80000000

// timing: 25 MHz tick derived from the 40 MHz clock by a 5/8 phase step
`define CLK_PERIOD_NS     25
`define TICK_STEP         4'h5
`define TICK_MOD          4'h8
`define FR_CLEAR_NS       160
`define FR_CLEAR_CYC      (`FR_CLEAR_NS / `CLK_PERIOD_NS)

`endif

// [inc/misc_csr_pkg.sv]
package misc_csr_pkg;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_REQ  = 3'b010,
		SEQ_DONE = 3'b100
	} seq_state_t;

	typedef logic [15:0] half_t;

endpackage : misc_csr_pkg

// [verif/mac_csr_model.sv]
`timescale 1ns/1ps

module mac_csr_model (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// request from the bank
	input  wire logic        mac_req_reg,
	input  wire logic        mac_rnw_reg,
	input  wire logic [7:0]  mac_addr_reg,
	input  wire logic [31:0] mac_wdata_reg,
	output logic             mac_ack,
	output logic [31:0]      mac_rdata,
	// bench control and record
	input  wire logic [3:0]  wait_cycles,
	output logic [7:0]       seen_addr,
	output logic [31:0]      seen_wdata,
	output logic             seen_rnw,
	output logic [7:0]       op_count
);
	logic [31:0] regs [0:255];
	logic [3:0]  wait_cnt;
	logic        served;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mac_ack    <= 1'b0;
			mac_rdata  <= 32'h5a5a5a5a;
			wait_cnt   <= 4'h0;
			served     <= 1'b0;
			seen_addr  <= 8'h00;
			seen_wdata <= 32'h00000000;
			seen_rnw   <= 1'b0;
			op_count   <= 8'h00;
		end else begin
			mac_ack <= 1'b0;
			// read data is only held in the ack cycle, garbage otherwise
			if (mac_ack)
				mac_rdata <= ~mac_rdata;
			if (!mac_req_reg) begin
				served   <= 1'b0;
				wait_cnt <= 4'h0;
			end else if (!served) begin
				if (wait_cnt >= wait_cycles) begin
					mac_ack    <= 1'b1;
					served     <= 1'b1;
					seen_addr  <= mac_addr_reg;
					seen_wdata <= mac_wdata_reg;
					seen_rnw   <= mac_rnw_reg;
					op_count   <= op_count + 8'h01;
					if (mac_rnw_reg)
						mac_rdata <= regs[mac_addr_reg];
					else
						regs[mac_addr_reg] <= mac_wdata_reg;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end
endmodule : mac_csr_model

// [verif/misc_system_csr_bank_tb.sv]
`timescale 1ns/1ps

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
	$display("[FAIL] %0t ns: got %h expected %h", $time, got, exp); end end

module misc_system_csr_bank_tb;
	logic        clk_sys, rst_b, host_rd, host_wr, timer_run, frame_dropped;
	logic [7:1]  host_addr;
	logic [15:0] host_wdata, host_rdata_reg, timer_load, d, d2;
	logic        lost_half_event_reg, swap_active_reg, mac_req_reg, mac_rnw_reg, mac_ack;
	logic [7:0]  mac_addr_reg, seen_addr, op_count;
	logic [31:0] mac_wdata_reg, mac_rdata, seen_wdata;
	logic        seen_rnw;
	logic [3:0]  wait_cycles;
	int          err_total, compares, cycles;
	logic [7:0]  ra [10] = '{8'h90, 8'h92, 8'h98, 8'h9a, 8'ha0, 8'ha4, 8'ha6, 8'ha8, 8'haa, 8'h80};
	logic [15:0] rv [10] = '{16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};

	misc_system_csr_bank i_misc_system_csr_bank (.clk_sys(clk_sys), .rst_b(rst_b),
		.host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
		.host_rdata_reg(host_rdata_reg), .timer_run(timer_run), .timer_load(timer_load),
		.frame_dropped(frame_dropped), .lost_half_event_reg(lost_half_event_reg),
		.swap_active_reg(swap_active_reg), .mac_req_reg(mac_req_reg), .mac_rnw_reg(mac_rnw_reg),
		.mac_addr_reg(mac_addr_reg), .mac_wdata_reg(mac_wdata_reg), .mac_ack(mac_ack),
		.mac_rdata(mac_rdata));

	mac_csr_model i_mac_csr_model (.clk_sys(clk_sys), .rst_b(rst_b), .mac_req_reg(mac_req_reg),
		.mac_rnw_reg(mac_rnw_reg), .mac_addr_reg(mac_addr_reg), .mac_wdata_reg(mac_wdata_reg),
		.mac_ack(mac_ack), .mac_rdata(mac_rdata), .wait_cycles(wait_cycles),
		.seen_addr(seen_addr), .seen_wdata(seen_wdata), .seen_rnw(seen_rnw),
		.op_count(op_count));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic results;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 4000) begin
			err_total++;
			$display("[FAIL] %0t ns: run did not finish", $time);
			results();
		end
	end

	task automatic do_reset;
		@(negedge clk_sys);
		rst_b = 1'b0;
		repeat (5) @(negedge clk_sys);
		rst_b = 1'b1;
	endtask : do_reset

	task automatic bus_rd(input logic [7:0] a, input logic drp, output logic [15:0] q);
		@(negedge clk_sys);
		host_addr     = a[7:1];
		host_rd       = 1'b1;
		frame_dropped = drp;
		@(negedge clk_sys);
		host_rd       = 1'b0;
		frame_dropped = 1'b0;
		q             = host_rdata_reg;
	endtask : bus_rd

	task automatic bus_wr(input logic [7:0] a, input logic [15:0] v);
		@(negedge clk_sys);
		host_addr  = a[7:1];
		host_wdata = v;
		host_wr    = 1'b1;
		@(negedge clk_sys);
		host_wr = 1'b0;
	endtask : bus_wr

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] q;
		bus_rd(a, 1'b0, q);
		`CHK(q, exp)
	endtask : rd_chk

	task automatic wait_idle;
		logic [15:0] q;
		int n;
		n = 0;
		q = 16'h8000;
		while (q[15] !== 1'b0 && n < 50) begin
			bus_rd(8'ha6, 1'b0, q);
			n++;
		end
		`CHK(q[15], 1'b0)
	endtask : wait_idle

	initial begin
		{host_rd, host_wr, timer_run, frame_dropped} = 4'h0;
		host_addr   = 7'h00;
		host_wdata  = 16'h0000;
		timer_load  = 16'h00ff;
		wait_cycles = 4'h6;
		rst_b       = 1'b0;
		repeat (5) @(negedge clk_sys);
		rst_b = 1'b1;
		// timer counts down while running, presets on stop
		timer_run = 1'b1;
		repeat (20) @(negedge clk_sys);
		bus_rd(8'h90, 1'b0, d);
		`CHK(d inside {[16'hffe0:16'hfffe]}, 1'b1)
		bus_rd(8'h90, 1'b0, d2);
		`CHK(d2 < d, 1'b1)
		timer_run = 1'b0;
		repeat (3) @(negedge clk_sys);
		rd_chk(8'h90, 16'hffff);
		bus_wr(8'h90, 16'h1234);
		rd_chk(8'h90, 16'hffff);
		rd_chk(8'h92, 16'h0000);
		// upper half first, long pause, then the low half must be the snapshot
		bus_rd(8'h9e, 1'b0, d);
		repeat (80) @(negedge clk_sys);
		bus_rd(8'h9c, 1'b0, d);
		bus_rd(8'h9c, 1'b0, d2);
		`CHK((d2 - d) inside {[16'd48:16'd58]}, 1'b1)
		bus_rd(8'h9e, 1'b0, d);
		// mid-run reset: tick count restarts near zero
		do_reset();
		repeat (7) @(negedge clk_sys);
		bus_rd(8'h9c, 1'b0, d);
		`CHK(d <= 16'd10, 1'b1)
		bus_rd(8'h9e, 1'b0, d);
		`CHK(d, 16'h0000)
		`CHK(swap_active_reg, 1'b0)
		for (int i = 0; i < 10; i++)
			rd_chk(ra[i], rv[i]);
		rd_chk(8'ha2, 16'h0000);
		// word order
		bus_wr(8'h98, 16'h1234);
		bus_wr(8'h9a, 16'h5678);
		rd_chk(8'h98, 16'h1234);
		rd_chk(8'h9a, 16'h5678);
		bus_wr(8'ha8, 16'haaaa);
		bus_wr(8'haa, 16'hbbbb);
		bus_wr(8'h98, 16'hffff);
		`CHK(swap_active_reg, 1'b0)
		bus_wr(8'h9a, 16'hffff);
		@(negedge clk_sys);
		`CHK(swap_active_reg, 1'b1)
		rd_chk(8'ha8, 16'hbbbb);
		rd_chk(8'haa, 16'haaaa);
		bus_wr(8'h98, 16'h0000);
		@(negedge clk_sys);
		`CHK(swap_active_reg, 1'b0)
		rd_chk(8'h98, 16'hffff);
		rd_chk(8'h9a, 16'h0000);
		bus_wr(8'h98, 16'h0000);
		// dropped frames, clear on read, drop during the clearing read
		repeat (3) begin
			@(negedge clk_sys);
			frame_dropped = 1'b1;
			@(negedge clk_sys);
			frame_dropped = 1'b0;
		end
		rd_chk(8'ha0, 16'h0003);
		`CHK(lost_half_event_reg, 1'b0)
		rd_chk(8'ha2, 16'h0000);
		bus_rd(8'ha0, 1'b1, d);
		`CHK(d, 16'h0000)
		rd_chk(8'ha2, 16'h0000);
		rd_chk(8'ha0, 16'h0001);
		rd_chk(8'ha2, 16'h0000);
		// slow indirect write, value writes while busy are dropped
		bus_wr(8'ha4, 16'h0042);
		bus_wr(8'ha8, 16'h5678);
		bus_wr(8'haa, 16'h1234);
		bus_wr(8'ha6, 16'h8000);
		rd_chk(8'ha6, 16'h8000);
		bus_wr(8'ha8, 16'hdead);
		wait_idle();
		`CHK(seen_addr, 8'h42)
		`CHK(seen_wdata, 32'h12345678)
		`CHK(seen_rnw, 1'b0)
		`CHK(op_count, 8'h01)
		rd_chk(8'ha8, 16'h5678);
		// prompt indirect read returns the written word
		wait_cycles = 4'h0;
		bus_wr(8'ha8, 16'h0000);
		bus_wr(8'haa, 16'h0000);
		bus_wr(8'ha6, 16'hc000);
		wait_idle();
		rd_chk(8'ha8, 16'h5678);
		rd_chk(8'haa, 16'h1234);
		`CHK(seen_rnw, 1'b1)
		rd_chk(8'ha4, 16'h0042);
		rd_chk(8'ha6, 16'h4000);
		// no start without the busy bit
		bus_wr(8'ha6, 16'h0000);
		repeat (5) @(negedge clk_sys);
		`CHK(op_count, 8'h02)
		rd_chk(8'ha6, 16'h0000);
		results();
	end
endmodule : misc_system_csr_bank_tb

// [verilog/mac_indirect_seq.sv]
`timescale 1ns/1ps
`include "misc_csr_defines.svh"

module mac_indirect_seq (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// request from the register bank
	input  wire logic        start,
	input  wire logic        rnw,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	// status back to the register bank
	output logic             busy_reg,
	output logic             done_reg,
	output logic [31:0]      rdata_reg,
	// mac register port
	output logic             mac_req_reg,
	output logic             mac_rnw_reg,
	output logic [7:0]       mac_addr_reg,
	output logic [31:0]      mac_wdata_reg,
	input  wire logic        mac_ack,
	input  wire logic [31:0] mac_rdata
);

	misc_csr_pkg::seq_state_t state_reg;

	// request is held until the mac acknowledges it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= misc_csr_pkg::SEQ_IDLE;
		end else begin
			case (state_reg)
				misc_csr_pkg::SEQ_IDLE: if (start) state_reg <= misc_csr_pkg::SEQ_REQ;
				misc_csr_pkg::SEQ_REQ:  if (mac_ack) state_reg <= misc_csr_pkg::SEQ_DONE;
				misc_csr_pkg::SEQ_DONE: state_reg <= misc_csr_pkg::SEQ_IDLE;
				default:                state_reg <= misc_csr_pkg::SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			busy_reg <= 1'b0;
		end else if (state_reg == misc_csr_pkg::SEQ_IDLE && start) begin
			busy_reg <= 1'b1; // [R14]
		end else if (state_reg == misc_csr_pkg::SEQ_DONE) begin
			busy_reg <= 1'b0; // [R14]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mac_req_reg   <= 1'b0;
			mac_rnw_reg   <= 1'b0;
			mac_addr_reg  <= 8'h00;
			mac_wdata_reg <= 32'h00000000;
		end else if (state_reg == misc_csr_pkg::SEQ_IDLE && start) begin
			mac_req_reg   <= 1'b1;
			mac_rnw_reg   <= rnw; // [R17]
			mac_addr_reg  <= addr; // [R18]
			mac_wdata_reg <= wdata; // [R19]
		end else if (state_reg == misc_csr_pkg::SEQ_REQ && mac_ack) begin
			mac_req_reg   <= 1'b0;
		end
	end

	// read data is captured a cycle before busy drops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			done_reg  <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			done_reg <= (state_reg == misc_csr_pkg::SEQ_REQ) && mac_ack;
			if (state_reg == misc_csr_pkg::SEQ_REQ && mac_ack && mac_rnw_reg) begin
				rdata_reg <= mac_rdata; // [R15]
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_busy_on_start: assert property ( // [R14]
		(state_reg == misc_csr_pkg::SEQ_IDLE && start) |=> busy_reg && mac_req_reg)
		else $error("busy not raised on start");
	a_busy_self_clear: assert property ( // [R14]
		done_reg |=> !busy_reg)
		else $error("busy did not clear after done");
	a_read_valid: assert property ( // [R15]
		(mac_req_reg && mac_ack && mac_rnw_reg) |=> done_reg && rdata_reg == $past(mac_rdata))
		else $error("read data not captured with done");
	c_mac_read: cover property (done_reg && mac_rnw_reg);
	c_mac_write: cover property (done_reg && !mac_rnw_reg);

endmodule : mac_indirect_seq

// [verilog/misc_system_csr_bank.sv]
`timescale 1ns/1ps
`include "misc_csr_defines.svh"

// How it works
// R01 - timer count reads in low 16 bits, upper bits zero, resets to ffff
// R02 - timer counts only while run is high, halts and presets when cleared
// R03 - swap not all ones: a[1] high reaches upper register half
// R04 - swap all ones: a[1] high reaches lower register half
// R05 - network fifo word order ignores the swap setting
// R06 - 32-bit tick counter clears at reset, steps at 25 mhz, wraps
// R07 - first halfword read snapshots the whole 32-bit tick count
// R08 - following read of the other half returns the snapshot
// R09 - tick counter may take up to 160 ns to show zero after reset
// R10 - tick counter never halts for power states
// R11 - lost frame tally counts each dropped receive frame, resets to zero
// R12 - reading the lost frame tally returns it then clears it
// R13 - event pulse when tally steps from just below half scale to half
// R14 - writing busy starts the indirect mac access; busy self-clears when done
// R15 - read data is valid in the value register when busy clears
// R16 - host leaves command and value alone while busy is set
// R17 - read_not_write selects read when one, write when zero; resets zero
// R18 - low byte of command selects the mac register; resets zero
// R19 - 32-bit value register carries write or read data; resets zero

module misc_system_csr_bank (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// host halfword bus (from the bus interface, same clock)
	input  wire logic [7:1]  host_addr,
	input  wire logic        host_rd,
	input  wire logic        host_wr,
	input  wire logic [15:0] host_wdata,
	output logic [15:0]      host_rdata_reg,
	// general purpose timer control
	input  wire logic        timer_run,
	input  wire logic [15:0] timer_load,
	// receive path
	input  wire logic        frame_dropped,
	output logic             lost_half_event_reg,
	// swap state for the host data path
	output logic             swap_active_reg,
	// mac register port
	output logic             mac_req_reg,
	output logic             mac_rnw_reg,
	output logic [7:0]       mac_addr_reg,
	output logic [31:0]      mac_wdata_reg,
	input  wire logic        mac_ack,
	input  wire logic [31:0] mac_rdata
);

	// picks one halfword of a 32-bit word
	function automatic misc_csr_pkg::half_t half_of(input logic [31:0] word,
		input logic upper);
		half_of = upper ? word[31:16] : word[15:0];
	endfunction : half_of

	// merges a written halfword into a 32-bit word
	function automatic logic [31:0] merge_half(input logic [31:0] word,
		input logic upper, input logic [15:0] data);
		merge_half = upper ? {data, word[15:0]} : {word[31:16], data};
	endfunction : merge_half

	logic [15:0] timer_cnt_reg;
	logic        timer_run_d_reg;
	logic [31:0] swap_reg;
	logic [3:0]  tick_phase_reg;
	logic        tick_reg;
	logic [31:0] tick_count_value_reg;
	logic [31:0] fr_snap_reg;
	logic        fr_pend_reg;
	logic [31:0] lost_cnt_reg;
	logic [31:0] lost_snap_reg;
	logic        lost_pend_reg;
	logic        cmd_rnw_reg;
	logic [7:0]  cmd_addr_reg;
	logic [31:0] value_reg;
	logic        seq_busy;
	logic        seq_done;
	logic [31:0] seq_rdata;
	logic [7:0]  reg_sel;
	logic        upper_sel;
	logic        seq_start;
	logic        cmd_busy_view;
	logic        rd_fr;
	logic        rd_lost;
	logic        wr_cmd;
	logic        wr_value;
	logic [4:0]  phase_sum;

	// halfword address decode, swapped only on the host side [R05]
	assign reg_sel   = {host_addr[7:2], 2'b00};
	assign upper_sel = host_addr[1] ^ swap_active_reg; // [R03] [R04]
	assign rd_fr     = host_rd && reg_sel == `OFS_TICK_COUNT;
	assign rd_lost   = host_rd && reg_sel == `OFS_LOST_FRAMES;
	assign cmd_busy_view = seq_busy | seq_done;
	// host must not touch command or value while busy, writes are dropped [R16]
	assign wr_cmd    = host_wr && reg_sel == `OFS_MAC_COMMAND && !cmd_busy_view;
	assign wr_value  = host_wr && reg_sel == `OFS_MAC_VALUE && !cmd_busy_view;
	assign seq_start = wr_cmd && upper_sel && host_wdata[`CMD_BUSY_BIT - 16]; // [R14]
	assign phase_sum = {1'b0, tick_phase_reg} + {1'b0, `TICK_STEP};

	// general purpose timer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			timer_cnt_reg   <= `TIMER_RST; // [R01]
			timer_run_d_reg <= 1'b0;
		end else begin
			timer_run_d_reg <= timer_run;
			if (timer_run_d_reg && !timer_run) begin
				timer_cnt_reg <= `TIMER_RST; // [R02]
			end else if (timer_run) begin
				if (timer_cnt_reg == 16'h0000) begin
					timer_cnt_reg <= timer_load;
				end else begin
					timer_cnt_reg <= timer_cnt_reg - 16'h0001; // [R02]
				end
			end
		end
	end

	// word swap control
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			swap_reg <= `SWAP_RST;
		end else if (host_wr && reg_sel == `OFS_HALF_ORDER) begin
			swap_reg <= merge_half(swap_reg, upper_sel, host_wdata);
		end
	end

	// only the exact all-ones pattern reverses the halves
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			swap_active_reg <= 1'b0;
		end else begin
			swap_active_reg <= (swap_reg == `SWAP_REVERSE); // [R03] [R04]
		end
	end

	// 25 mhz tick: five steps of eight per clock period, no power gating [R10]
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tick_phase_reg <= 4'h0;
			tick_reg       <= 1'b0;
		end else if (phase_sum >= {1'b0, `TICK_MOD}) begin
			tick_phase_reg <= phase_sum[3:0] - `TICK_MOD;
			tick_reg       <= 1'b1;
		end else begin
			tick_phase_reg <= phase_sum[3:0];
			tick_reg       <= 1'b0;
		end
	end

	// free running count clears at reset within one cycle, well under
	// the allowed settling time [R09]
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tick_count_value_reg <= 32'h00000000; // [R06]
		end else if (tick_reg) begin
			tick_count_value_reg <= tick_count_value_reg + 32'h00000001; // [R06] [R10]
		end
	end

	// snapshot on the first halfword, released by the next read of either half
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fr_snap_reg <= 32'h00000000;
			fr_pend_reg <= 1'b0;
		end else if (rd_fr) begin
			if (!fr_pend_reg) begin
				fr_snap_reg <= tick_count_value_reg; // [R07]
				fr_pend_reg <= 1'b1;
			end else begin
				fr_pend_reg <= 1'b0; // [R08]
			end
		end
	end

	// dropped frame tally; a drop in the clearing cycle is kept
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lost_cnt_reg <= 32'h00000000; // [R11]
		end else if (rd_lost && !lost_pend_reg) begin
			lost_cnt_reg <= frame_dropped ? 32'h00000001 : 32'h00000000; // [R12]
		end else if (frame_dropped) begin
			lost_cnt_reg <= lost_cnt_reg + 32'h00000001; // [R11]
		end
	end

	// cleared value is still readable as the second halfword
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lost_snap_reg <= 32'h00000000;
			lost_pend_reg <= 1'b0;
		end else if (rd_lost) begin
			if (!lost_pend_reg) begin
				lost_snap_reg <= lost_cnt_reg; // [R12]
				lost_pend_reg <= 1'b1;
			end else begin
				lost_pend_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lost_half_event_reg <= 1'b0;
		end else begin
			lost_half_event_reg <= frame_dropped && !(rd_lost && !lost_pend_reg)
				&& lost_cnt_reg == `LOST_HALF_PREV; // [R13]
		end
	end

	// indirect command fields
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmd_rnw_reg  <= 1'b0; // [R17]
			cmd_addr_reg <= 8'h00; // [R18]
		end else if (wr_cmd) begin
			if (upper_sel) begin
				cmd_rnw_reg <= host_wdata[`CMD_RNW_BIT - 16]; // [R17]
			end else begin
				cmd_addr_reg <= host_wdata[`CMD_ADDR_MSB:0]; // [R18]
			end
		end
	end

	// value register takes host writes and mac read results
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			value_reg <= 32'h00000000; // [R19]
		end else if (seq_done && mac_rnw_reg) begin
			value_reg <= seq_rdata; // [R15]
		end else if (wr_value) begin
			value_reg <= merge_half(value_reg, upper_sel, host_wdata); // [R19]
		end
	end

	mac_indirect_seq u_seq (
		.clk_sys       (clk_sys),
		.rst_b         (rst_b),
		.start         (seq_start),
		.rnw           (host_wdata[`CMD_RNW_BIT - 16]),
		.addr          (cmd_addr_reg),
		.wdata         (value_reg),
		.busy_reg      (seq_busy),
		.done_reg      (seq_done),
		.rdata_reg     (seq_rdata),
		.mac_req_reg   (mac_req_reg),
		.mac_rnw_reg   (mac_rnw_reg),
		.mac_addr_reg  (mac_addr_reg),
		.mac_wdata_reg (mac_wdata_reg),
		.mac_ack       (mac_ack),
		.mac_rdata     (mac_rdata)
	);

	// registered read data; unmapped offsets read zero
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			host_rdata_reg <= 16'h0000;
		end else if (host_rd) begin
			case (reg_sel)
				`OFS_TIMER_NOW:
					host_rdata_reg <= half_of({16'h0000, timer_cnt_reg}, upper_sel); // [R01]
				`OFS_HALF_ORDER:
					host_rdata_reg <= half_of(swap_reg, upper_sel);
				`OFS_TICK_COUNT:
					host_rdata_reg <= half_of(fr_pend_reg ? fr_snap_reg : tick_count_value_reg,
						upper_sel); // [R07] [R08]
				`OFS_LOST_FRAMES:
					host_rdata_reg <= half_of(lost_pend_reg ? lost_snap_reg : lost_cnt_reg,
						upper_sel); // [R12]
				`OFS_MAC_COMMAND:
					host_rdata_reg <= half_of({cmd_busy_view, cmd_rnw_reg, 22'h000000,
						cmd_addr_reg}, upper_sel); // [R14]
				`OFS_MAC_VALUE:
					host_rdata_reg <= half_of(value_reg, upper_sel); // [R19]
				default:
					host_rdata_reg <= 16'h0000;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_timer_halts: assert property ( // [R02]
		(!timer_run && !timer_run_d_reg) |=> $stable(timer_cnt_reg))
		else $error("timer moved while halted");
	a_timer_preset: assert property ( // [R02]
		(timer_run_d_reg && !timer_run) |=> timer_cnt_reg == 16'hffff)
		else $error("timer not preset on halt");
	a_timer_upper_zero: assert property ( // [R01]
		(host_rd && reg_sel == `OFS_TIMER_NOW && upper_sel) |=> host_rdata_reg == 16'h0000)
		else $error("timer upper half not zero");
	a_swap_reverse: assert property ( // [R04]
		(host_rd && reg_sel == `OFS_MAC_VALUE && swap_reg == `SWAP_REVERSE
			&& swap_active_reg && !host_addr[1]) |=> host_rdata_reg == $past(value_reg[31:16]))
		else $error("swapped read did not reach upper half");
	a_swap_normal: assert property ( // [R03]
		(host_rd && reg_sel == `OFS_MAC_VALUE && !swap_active_reg && host_addr[1])
			|=> host_rdata_reg == $past(value_reg[31:16]))
		else $error("plain read did not reach upper half");
	a_tick_step: assert property ( // [R06]
		tick_reg |=> tick_count_value_reg == $past(tick_count_value_reg) + 32'h00000001)
		else $error("tick counter did not step");
	a_tick_rate: assert property ( // [R06] [R10]
		tick_reg |-> ##[1:2] tick_reg)
		else $error("tick spacing wrong");
	a_tick_triple: assert property ( // [R06]
		(tick_reg && $past(tick_reg)) |=> !tick_reg)
		else $error("three ticks in a row");
	a_snap_hold: assert property ( // [R07] [R08]
		(rd_fr && !fr_pend_reg) |=> fr_pend_reg && fr_snap_reg == $past(tick_count_value_reg))
		else $error("tick snapshot not taken");
	a_lost_clear: assert property ( // [R12]
		(rd_lost && !lost_pend_reg && !frame_dropped) |=> lost_cnt_reg == 32'h00000000)
		else $error("lost tally not cleared on read");
	a_lost_half: assert property ( // [R13]
		(frame_dropped && !rd_lost && lost_cnt_reg == `LOST_HALF_PREV)
			|=> lost_half_event_reg && lost_cnt_reg == `LOST_HALF_AT)
		else $error("half scale event missing");
	a_busy_read: assert property ( // [R14] [R15]
		($fell(seq_busy) && mac_rnw_reg) |-> value_reg == seq_rdata)
		else $error("read value not present when busy cleared");
	a_timer_step: assert property ( // [R02]
		(timer_run && timer_cnt_reg != 16'h0000)
			|=> timer_cnt_reg == $past(timer_cnt_reg) - 16'h0001)
		else $error("running timer did not step down");
	a_timer_reload: assert property ( // [R02]
		(timer_run && timer_cnt_reg == 16'h0000) |=> timer_cnt_reg == $past(timer_load))
		else $error("timer did not reload at zero");
	a_lost_step: assert property ( // [R11]
		(frame_dropped && !(rd_lost && !lost_pend_reg))
			|=> lost_cnt_reg == $past(lost_cnt_reg) + 32'h00000001)
		else $error("lost tally did not count a drop");
	a_lost_drop_clear: assert property ( // [R12]
		(rd_lost && !lost_pend_reg && frame_dropped) |=> lost_cnt_reg == 32'h00000001)
		else $error("drop in clearing read was lost");
	a_snap_release: assert property ( // [R08]
		(rd_fr && fr_pend_reg) |=> !fr_pend_reg && $stable(fr_snap_reg))
		else $error("tick snapshot not released intact");
	a_value_locked: assert property ( // [R16]
		(host_wr && reg_sel == `OFS_MAC_VALUE && seq_busy && !seq_done) |=> $stable(value_reg))
		else $error("value changed by a write while busy");
	a_swap_follow: assert property ( // [R03] [R04]
		1'b1 |=> swap_active_reg == ($past(swap_reg) == `SWAP_REVERSE))
		else $error("swap state does not follow the control word");

	c_snapshot_pair: cover property ((rd_fr && !fr_pend_reg) ##[1:8] (rd_fr && fr_pend_reg));
	c_lost_half: cover property (lost_half_event_reg);
	c_swap_on: cover property (swap_active_reg && host_rd);

endmodule : misc_system_csr_bank
